// ===== rsh_consts.vh
// Operation
// [RULE1] Stay-on-secondary 0 returns to primary when good; 1 stays on secondary.
// [RULE2] Manual mode: secondary input powered only when its power-on bit is 1.
// [RULE3] Manual mode: primary input powered only when its power-on bit is 1.
// [RULE4] Reference-mode bit: 0 single-ended (default), 1 differential.
// [RULE5] Software selects single-ended before using switchover or two inputs.
// [RULE6] Holdover control bit 4 set disables PLL status readback.
// [RULE7] Comparator enabled in automatic holdover decides previous lock.
// [RULE8] Comparator disabled: holdover controller sees lock pin as true.
// [RULE9] Comparator output visible on monitor and status pins when selected; code drives it only on lock_cmp_monitor_n.
// [RULE10] Holdover enabled only when control bits 2 and 0 both set.
// [RULE11] Software keeps automatic holdover off during VCO calibration.
// [RULE12] External holdover bit 1: internal controller off, pin level decides.
// [RULE13] External holdover bit 0: internal circuit decides holdover entry and exit.
// [RULE14] VCO calibration status is read-only bit 6 of status register.
// [RULE15] Calibration status reads 0 until finished, 1 after.
// [RULE16] Automatic-switchover bit: 0 manual, 1 automatic; power bits manual only.
// [RULE17] Holdover-active read-only bit shows holdover state, not enable.
// [RULE18] Automatic switchover keeps both reference receivers powered.
// [RULE19] External holdover pin passes two flip-flops before use.
`ifndef RSH_CONSTS_VH
`define RSH_CONSTS_VH
// ****************************************
// Register map
// ****************************************
`define RSH_ADDR_REFSEL   10'h01C
`define RSH_ADDR_HOLD     10'h01D
`define RSH_ADDR_STATUS   10'h01F
`define RSH_REFSEL_RESET  8'h00
`define RSH_HOLD_RESET    8'h00
// ****************************************
// Reference select fields
// ****************************************
`define RSH_RS_DIFF       0
`define RSH_RS_PRI_PWR    1
`define RSH_RS_SEC_PWR    2
`define RSH_RS_STAY_SEC   3
`define RSH_RS_AUTO       4
`define RSH_RS_USE_PIN    5
`define RSH_RS_SEL_SEC    6
// ****************************************
// Holdover control fields
// ****************************************
`define RSH_HC_EN_A       0
`define RSH_HC_EXT        1
`define RSH_HC_EN_B       2
`define RSH_HC_CMP_EN     3
`define RSH_HC_STAT_DIS   4
// ****************************************
// Status fields
// ****************************************
`define RSH_ST_LOCK       0
`define RSH_ST_PRI_GOOD   1
`define RSH_ST_SEC_GOOD   2
`define RSH_ST_VCO_GOOD   3
`define RSH_ST_SEC_SEL    4
`define RSH_ST_HOLD       5
`define RSH_ST_CAL_DONE   6
`endif

// ===== rsh_ctrl.v
`timescale 1ns/10ps
`include "rsh_consts.vh"
module rsh_ctrl (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire [9:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       primary_ref_good,
	input  wire       secondary_ref_good,
	input  wire       vco_good,
	input  wire       pll_locked,
	input  wire       vco_cal_done,
	input  wire       ref_sel_pin,
	input  wire       ext_hold_pin,
	input  wire       lock_cmp_out,
	output reg        primary_ref_pwr,
	output reg        secondary_ref_pwr,
	output reg        ref_differential,
	output reg        secondary_selected,
	output reg        holdover_active,
	output reg        lock_cmp_enable,
	output reg        lock_cmp_monitor_n
);
	// ****************************************
	// Registers
	// ****************************************
	reg  [7:0] reference_select_control;
	reg  [7:0] holdover_and_lock_pin_control;
	wire [7:0] pin_s;
	wire       hold_state;
	reg        next_sec_sel;
	reg  [7:0] status_word;

	function is_addr;
		input [9:0] a;
		input [9:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reference_select_control      <= `RSH_REFSEL_RESET;
			holdover_and_lock_pin_control <= `RSH_HOLD_RESET;
		end else if (reg_wr) begin
			if (is_addr(reg_addr, `RSH_ADDR_REFSEL))
				reference_select_control <= {1'b0, reg_wdata[6:0]};
			if (is_addr(reg_addr, `RSH_ADDR_HOLD))
				holdover_and_lock_pin_control <= {3'h0, reg_wdata[4:0]};
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Status levels may come from analog monitors, so all are synchronised
	rsh_sync #(.WIDTH(8)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({ext_hold_pin, lock_cmp_out, ref_sel_pin, vco_cal_done,
			pll_locked, vco_good, secondary_ref_good, primary_ref_good}),
		.sync_out (pin_s)
	); //RULE19

	wire pri_good = pin_s[0];
	wire sec_good = pin_s[1];
	wire cal_s    = pin_s[4];
	wire sel_pin  = pin_s[5];
	wire cmp_s    = pin_s[6];
	wire ext_s    = pin_s[7];

	wire auto_sw  = reference_select_control[`RSH_RS_AUTO] &
		~reference_select_control[`RSH_RS_DIFF]; //RULE16
	wire cmp_en   = holdover_and_lock_pin_control[`RSH_HC_CMP_EN];
	wire ext_mode = holdover_and_lock_pin_control[`RSH_HC_EXT];
	wire hold_en  = holdover_and_lock_pin_control[`RSH_HC_EN_A] &
		holdover_and_lock_pin_control[`RSH_HC_EN_B]; //RULE10
	// Disabled comparator reads as locked
	wire was_lock = cmp_en ? ~cmp_s : 1'b1; //RULE7 RULE8
	wire cur_ref_good = secondary_selected ? sec_good : pri_good;

	// ****************************************
	// Holdover controller
	// ****************************************
	rsh_holdover u_hold (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.hold_enable (hold_en),
		.ext_mode    (ext_mode),
		.ext_level   (ext_s),
		.ref_good    (cur_ref_good),
		.was_locked  (was_lock),
		.hold_active (hold_state)
	);

	// ****************************************
	// Reference selection
	// ****************************************
	always @* begin
		next_sec_sel = secondary_selected;
		if (reference_select_control[`RSH_RS_DIFF])
			next_sec_sel = 1'b0;
		else if (auto_sw) begin
			if (!secondary_selected && !pri_good && sec_good)
				next_sec_sel = 1'b1;
			else if (secondary_selected && pri_good &&
				!reference_select_control[`RSH_RS_STAY_SEC])
				next_sec_sel = 1'b0; //RULE1
		end else if (reference_select_control[`RSH_RS_USE_PIN])
			next_sec_sel = sel_pin;
		else
			next_sec_sel = reference_select_control[`RSH_RS_SEL_SEC];
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_selected <= 1'b0;
			primary_ref_pwr    <= 1'b0;
			secondary_ref_pwr  <= 1'b0;
			ref_differential   <= 1'b0;
			holdover_active    <= 1'b0;
			lock_cmp_enable    <= 1'b0;
			// Idle level in reset, so no false comparator event
			lock_cmp_monitor_n <= 1'b1;
		end else begin
			secondary_selected <= next_sec_sel;
			primary_ref_pwr    <= auto_sw |
				reference_select_control[`RSH_RS_PRI_PWR]; //RULE3 RULE18
			secondary_ref_pwr  <= auto_sw |
				reference_select_control[`RSH_RS_SEC_PWR]; //RULE2 RULE18
			ref_differential   <=
				reference_select_control[`RSH_RS_DIFF]; //RULE4
			holdover_active    <= hold_state;
			lock_cmp_enable    <= cmp_en;
			// Active low, matching the monitor pin convention
			lock_cmp_monitor_n <= ~(cmp_en & cmp_s); //RULE9
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always @* begin
		status_word = 8'h00;
		status_word[`RSH_ST_LOCK]     = pin_s[3];
		status_word[`RSH_ST_PRI_GOOD] = pri_good;
		status_word[`RSH_ST_SEC_GOOD] = sec_good;
		status_word[`RSH_ST_VCO_GOOD] = pin_s[2];
		status_word[`RSH_ST_SEC_SEL]  = secondary_selected;
		status_word[`RSH_ST_HOLD]     = hold_state; //RULE17
		status_word[`RSH_ST_CAL_DONE] = cal_s; //RULE14 RULE15
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			if (is_addr(reg_addr, `RSH_ADDR_REFSEL))
				reg_rdata <= reference_select_control;
			else if (is_addr(reg_addr, `RSH_ADDR_HOLD))
				reg_rdata <= holdover_and_lock_pin_control;
			else if (is_addr(reg_addr, `RSH_ADDR_STATUS))
				reg_rdata <= holdover_and_lock_pin_control[`RSH_HC_STAT_DIS]
					? 8'h00 : status_word; //RULE6
			else
				reg_rdata <= 8'h00;
		end
	end
endmodule

// ===== rsh_ctrl_chk.sv
`timescale 1ns/10ps
module rsh_ctrl_chk (
	input wire       sys_clk,
	input wire       rst_n,
	input wire [9:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       ext_hold_pin,
	input wire       primary_ref_pwr,
	input wire       secondary_ref_pwr,
	input wire       ref_differential,
	input wire       holdover_active,
	input wire       lock_cmp_enable
);
	// ****
	// Shadow copies of the two control registers
	// ****
	reg  [6:0] rs;
	reg  [4:0] hc;
	wire       en = hc[0] & hc[2];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs <= 7'h00;
			hc <= 5'h00;
		end else if (reg_wr && reg_addr == 10'h01C) begin
			rs <= reg_wdata[6:0];
		end else if (reg_wr && reg_addr == 10'h01D) begin
			hc <= reg_wdata[4:0];
		end
	end
	rd_refsel_a: assert property (reg_rd && reg_addr == 10'h01C
		|=> reg_rdata == {1'b0, $past(rs)}) else $error("refsel readback");
	rd_hold_a: assert property (reg_rd && reg_addr == 10'h01D
		|=> reg_rdata == {3'h0, $past(hc)}) else $error("hold readback");
	stat_off_a: assert property (reg_rd && reg_addr == 10'h01F && hc[4]
		|=> reg_rdata == 8'h00) else $error("status not blanked");
	rd_unmap_a: assert property (reg_rd && !(reg_addr inside
		{10'h01C, 10'h01D, 10'h01F}) |=> reg_rdata == 8'h00) else $error("unmapped");
	pri_pwr_a: assert property (!$past(rs[0]) |->
		primary_ref_pwr == $past(rs[1] | rs[4])) else $error("primary power");
	sec_pwr_a: assert property (!$past(rs[0]) |->
		secondary_ref_pwr == $past(rs[2] | rs[4])) else $error("second power");
	diff_mode_a: assert property (
		ref_differential == $past(rs[0])) else $error("reference mode");
	cmp_en_a: assert property (
		lock_cmp_enable == $past(hc[3])) else $error("comparator enable");
	hold_off_a: assert property (!$past(en) && !$past(en, 2)
		&& !$past(en, 3) |-> !holdover_active) else $error("hold when off");
	// Six quiet cycles cover the pin synchroniser, the holdover state register and the output register
	ext_hold_a: assert property ((en && hc[1] && $stable(ext_hold_pin)) [*6]
		|-> holdover_active == ext_hold_pin) else $error("external hold");
endmodule
bind rsh_ctrl rsh_ctrl_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_hold_pin(ext_hold_pin),
	.primary_ref_pwr(primary_ref_pwr),
	.secondary_ref_pwr(secondary_ref_pwr),
	.ref_differential(ref_differential),
	.holdover_active(holdover_active), .lock_cmp_enable(lock_cmp_enable));

// ===== rsh_holdover.v
`timescale 1ns/10ps
`include "rsh_consts.vh"
module rsh_holdover (
	input  wire sys_clk,
	input  wire rst_n,
	input  wire hold_enable,
	input  wire ext_mode,
	input  wire ext_level,
	input  wire ref_good,
	input  wire was_locked,
	output reg  hold_active
);
	// ****************************************
	// Holdover state
	// ****************************************
	reg next_hold;

	always @* begin
		next_hold = 1'b0;
		if (hold_enable) begin //RULE10
			if (ext_mode)
				next_hold = ext_level; //RULE12
			else if (hold_active)
				next_hold = ~ref_good; //RULE13
			else
				next_hold = ~ref_good & was_locked; //RULE13
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			hold_active <= 1'b0;
		else
			hold_active <= next_hold;
	end
endmodule

// ===== rsh_sync.v
`timescale 1ns/10ps
`include "rsh_consts.vh"
module rsh_sync #(
	parameter WIDTH = 1
) (
	input  wire             sys_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
	logic       sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic       rsp = 0;
	logic       pg = 0, sg = 0, vg = 0, pl = 0, cd = 0, eh = 0, lc = 0;
	logic [9:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	wire  [7:0] reg_rdata;
	wire        pp, sp, rdf, ssel, hact, cen, cmon;
	int         num_errors = 0, tests_run = 0;
	// Rows: control word and expected {primary, secondary, differential}
	logic [7:0] wv [6] = '{8'h02, 8'h04, 8'h10, 8'h01, 8'hFF, 8'h00};
	logic [2:0] ev [6] = '{3'h4, 3'h2, 3'h6, 3'h1, 3'h7, 3'h0};
	rsh_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .primary_ref_good(pg),
		.secondary_ref_good(sg), .vco_good(vg), .pll_locked(pl),
		.vco_cal_done(cd), .ref_sel_pin(rsp), .ext_hold_pin(eh),
		.lock_cmp_out(lc), .primary_ref_pwr(pp), .secondary_ref_pwr(sp),
		.ref_differential(rdf), .secondary_selected(ssel),
		.holdover_active(hact), .lock_cmp_enable(cen),
		.lock_cmp_monitor_n(cmon));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// ****
	// Shared tasks, all entered on a falling edge
	// ****
	task chk(input string n, input logic [7:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask
	task rd(input logic [9:0] a, input logic [7:0] e, input string n);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		cyc(1);
		chk(n, reg_rdata, e);
	endtask
	task hv(input logic [7:0] d, input logic p, e);
		wr(10'h01D, d);
		eh = p;
		cyc(6);
		chk("holdover", {7'h0, hact}, {7'h0, e});
	endtask
	task ps(input logic p, e);
		pg = p;
		cyc(6);
		chk("sec_sel", {7'h0, ssel}, {7'h0, e});
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cyc(6);
		rst_n = 1;
		rd(10'h01C, 8'h00, "refsel rst");
		rd(10'h01D, 8'h00, "hold rst");
		rd(10'h01F, 8'h00, "status rst");
		for (int i = 0; i < 6; i++) begin
			wr(10'h01C, wv[i]);
			cyc(2);
			chk("ref out", {5'h0, pp, sp, rdf}, {5'h0, ev[i]});
			rd(10'h01C, {1'b0, wv[i][6:0]}, "refsel");
		end
		$display("reference rows done");
		// Calibration moves only while holdover is off
		{pg, vg, pl, cd} = 4'hF;
		cyc(3);
		rd(10'h01F, 8'h4B, "status");
		wr(10'h01F, 8'hFF);
		rd(10'h01F, 8'h4B, "status ro");
		cd = 0;
		cyc(3);
		rd(10'h01F, 8'h0B, "cal");
		wr(10'h01D, 8'hFF);
		rd(10'h01F, 8'h00, "status off");
		rd(10'h01D, 8'h1F, "hold rb");
		rd(10'h3FF, 8'h00, "unmapped");
		$display("status done");
		hv(8'h07, 1, 1);
		rd(10'h01F, 8'h2B, "hold stat");
		hv(8'h03, 1, 0);
		hv(8'h06, 1, 0);
		hv(8'h07, 0, 0);
		pg = 0;
		hv(8'h05, 1, 1);
		pg = 1;
		hv(8'h05, 1, 0);
		pg = 0;
		lc = 1;
		hv(8'h0D, 1, 0);
		chk("cmp mon", {7'h0, cmon}, 8'h00);
		lc = 0;
		hv(8'h0D, 1, 1);
		chk("cmp mon", {7'h0, cmon}, 8'h01);
		chk("cmp en", {7'h0, cen}, 8'h01);
		pg = 1;
		hv(8'h00, 0, 0);
		$display("holdover done");
		sg = 1;
		wr(10'h01C, 8'h10);
		ps(0, 1);
		ps(1, 0);
		wr(10'h01C, 8'h18);
		ps(0, 1);
		ps(1, 1);
		$display("switchover done");
		wr(10'h01C, 8'h00);
		cyc(3);
		chk("man pri", {7'h0, ssel}, 8'h00);
		wr(10'h01C, 8'h40);
		cyc(3);
		chk("man sec", {7'h0, ssel}, 8'h01);
		rsp = 1;
		wr(10'h01C, 8'h20);
		cyc(3);
		chk("pin sec", {7'h0, ssel}, 8'h01);
		rsp = 0;
		cyc(3);
		chk("pin pri", {7'h0, ssel}, 8'h00);
		$display("manual select done");
		// Mid-run reset must clear both control registers
		wr(10'h01D, 8'h1F);
		rst_n = 0;
		cyc(2);
		chk("rst mon", {7'h0, cmon}, 8'h01);
		rst_n = 1;
		rd(10'h01D, 8'h00, "hold rst2");
		rd(10'h01C, 8'h00, "refsel rst2");
		$display("reset done");
		test_done;
	end
endmodule
